// >>> l1ctl_mem_model.sv
// word-wide memory model facing one cache controller
// assumes requests are held until ack and one word moves per ack
`timescale 1ns/1ps
`default_nettype none
module l1ctl_mem_model #(
  parameter int DLY = 0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output var logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] q = 32'h0;
  int cnt = 0;
  int n_wr = 0;
  initial ack = 1'b0;
  // inverse outside ack, so a stale word never looks valid
  assign rdata = ack ? q : ~q;
  always @(posedge sys_clk) begin
    ack <= 1'b0;
    if (reset) begin
      cnt <= 0;
    end else if (req && !ack) begin
      if (cnt == DLY) begin
        ack <= 1'b1;
        cnt <= 0;
        if (we) begin
          mem[addr] = wdata;
          n_wr++;
        end
        q <= mem.exists(addr) ? mem[addr] : addr ^ 32'hc3c3_c3c3;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : l1ctl_mem_model
`default_nettype wire

// >>> l1ctl_pkg.sv
// constants, state encoding and geometry for the level-one cache control logic
// assumes a single core clock and a synchronous active-high reset
package l1ctl_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned TAG_W = 22;
  localparam int unsigned TAG_LSB = 10;
  localparam int unsigned WAYS = 4;
  localparam int unsigned WAY_W = 2;
  localparam int unsigned LINE_BYTES = 16;
  localparam int unsigned LINE_WORDS = 4;
  localparam int unsigned WSEL_W = 2;
  localparam int unsigned WSEL_LSB = 2;
  localparam int unsigned LINE_LSB = 4;
  localparam int unsigned LINE_ADDR_W = 28;
  localparam int unsigned AGE_W = 2;
  localparam int unsigned IC_BYTES = 16384;
  localparam int unsigned DC_BYTES = 4096;
  localparam int unsigned IC_SETS = IC_BYTES / (WAYS * LINE_BYTES);
  localparam int unsigned DC_SETS = DC_BYTES / (WAYS * LINE_BYTES);
  localparam int unsigned DC_IDX_W = 6;
  localparam logic [WSEL_W-1:0] LAST_WORD = 2'h3;
  localparam logic [WSEL_W-1:0] FIRST_WORD = 2'h0;
  localparam logic [AGE_W-1:0] AGE_NEWEST = 2'h0;

  // gray along idle -> fill -> install; the step from install back to idle flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_INST = 2'b11,
    ST_WB = 2'b10
  } l1ctl_state_type;
endpackage : l1ctl_pkg

// >>> l1ctl_top.sv
// four-way cache controllers for instruction and data sides, plus their top
// assumes the core holds a request until it sees the answer pulse, and that
// memory answers each word request with one ack cycle
`timescale 1ns/1ps
`default_nettype none

module l1ctl_cache #(
  parameter bit IS_DATA = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_cop,
  input wire logic cpu_lock,
  input wire logic [31:0] cpu_va,
  input wire logic [31:0] cpu_pa,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_rsp,
  output logic [31:0] cpu_rdata,
  output logic cpu_busy,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  localparam int unsigned SETS = IS_DATA ? l1ctl_pkg::DC_SETS : l1ctl_pkg::IC_SETS;
  localparam int unsigned IDX_W = $clog2(SETS);
  localparam int unsigned NL = SETS * l1ctl_pkg::WAYS;
  localparam int unsigned LW = l1ctl_pkg::WORD_W;

  typedef logic [l1ctl_pkg::LINE_WORDS-1:0][LW-1:0] l1ctl_line_type;
  typedef logic [l1ctl_pkg::WAYS-1:0][l1ctl_pkg::AGE_W-1:0] l1ctl_ages_type;

  typedef struct packed {
    l1ctl_pkg::l1ctl_state_type st;
    logic rsp;
    logic [31:0] rdata;
    logic busy;
    logic mreq;
    logic mwe;
    logic [31:0] maddr;
    logic [31:0] mwdata;
    logic [SETS-1:0][l1ctl_pkg::WAYS-1:0] vld;
    logic [SETS-1:0][l1ctl_pkg::WAYS-1:0] lck;
    logic [SETS-1:0][l1ctl_pkg::WAYS-1:0] drt;
    logic [SETS-1:0] [l1ctl_pkg::WAYS-1:0][l1ctl_pkg::AGE_W-1:0] lru;
    logic [IDX_W-1:0] idx;
    logic [l1ctl_pkg::TAG_W-1:0] ptag;
    logic [l1ctl_pkg::LINE_ADDR_W-1:0] pline;
    logic [l1ctl_pkg::WSEL_W-1:0] word;
    logic [l1ctl_pkg::WAY_W-1:0] way;
    logic we;
    logic [31:0] wdata;
    logic nofill;
    logic answered;
    logic [l1ctl_pkg::WSEL_W-1:0] cnt;
    l1ctl_line_type fbuf;
    logic [l1ctl_pkg::LINE_WORDS-1:0] fbufv;
  } l1ctl_regs_type;

  l1ctl_regs_type s_r;
  l1ctl_regs_type s_nxt;

  // tag and data storage; valid, lock, dirty and ages live in the register set
  // so that reset clears them
  logic [l1ctl_pkg::TAG_W-1:0] tag_mem [NL];
  l1ctl_line_type data_mem [NL];

  logic tag_we;
  logic data_we;
  logic [IDX_W+l1ctl_pkg::WAY_W-1:0] wr_addr;
  l1ctl_line_type data_wline;

  logic [IDX_W-1:0] rd_idx;
  logic [l1ctl_pkg::WAYS-1:0][l1ctl_pkg::TAG_W-1:0] tag_q;
  l1ctl_line_type line_q [l1ctl_pkg::WAYS];
  logic [l1ctl_pkg::WAYS-1:0] hit_v;
  logic hit;
  logic [l1ctl_pkg::WAY_W-1:0] hit_way;
  logic vic_found;
  logic [l1ctl_pkg::WAY_W-1:0] vic_way;
  logic take;
  logic [l1ctl_pkg::TAG_W-1:0] req_tag;
  logic [l1ctl_pkg::WSEL_W-1:0] req_word;

  // selected way becomes newest; every other way not older than it ages by one,
  // so the all-zero ages left by reset spread into a strict order, never past 3
  function automatic l1ctl_ages_type touch(input l1ctl_ages_type a,
                                           input logic [l1ctl_pkg::WAY_W-1:0] w);
    l1ctl_ages_type r;
    r = a;
    for (int i = 0; i < l1ctl_pkg::WAYS; i++) begin
      if (i[l1ctl_pkg::WAY_W-1:0] != w && a[i] <= a[w]) begin
        r[i] = a[i] + 2'h1;
      end
    end
    r[w] = l1ctl_pkg::AGE_NEWEST;
    return r;
  endfunction : touch

  // the set is picked from the virtual address while the physical tag comes in
  assign rd_idx = (s_r.st == l1ctl_pkg::ST_IDLE) ? cpu_va[l1ctl_pkg::LINE_LSB +: IDX_W] : s_r.idx;
  assign req_tag = cpu_pa[l1ctl_pkg::TAG_LSB +: l1ctl_pkg::TAG_W];
  assign req_word = cpu_va[l1ctl_pkg::WSEL_LSB +: l1ctl_pkg::WSEL_W];
  assign take = cpu_req && !s_r.rsp;

  always_comb begin
    hit_v = '0;
    hit = 1'b0;
    hit_way = '0;
    vic_found = 1'b0;
    vic_way = '0;
    for (int w = 0; w < l1ctl_pkg::WAYS; w++) begin
      tag_q[w] = tag_mem[{rd_idx, 2'(w)}];
      line_q[w] = data_mem[{rd_idx, 2'(w)}];
      hit_v[w] = s_r.vld[rd_idx][w] && (tag_q[w] == req_tag);
      if (hit_v[w]) begin
        hit = 1'b1;
        hit_way = 2'(w);
      end
    end
    // an invalid unlocked way wins, else the oldest unlocked one
    for (int w = 0; w < l1ctl_pkg::WAYS; w++) begin
      if (!s_r.lck[rd_idx][w]) begin
        if (!vic_found || !s_r.vld[rd_idx][w] ||
            (s_r.vld[rd_idx][vic_way] && s_r.lru[rd_idx][w] > s_r.lru[rd_idx][vic_way])) begin
          if (!(vic_found && !s_r.vld[rd_idx][vic_way])) begin
            vic_way = 2'(w);
          end
        end
        vic_found = 1'b1;
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp = 1'b0;
    tag_we = 1'b0;
    data_we = 1'b0;
    wr_addr = {s_r.idx, s_r.way};
    data_wline = s_r.fbuf;
    case (s_r.st)
      l1ctl_pkg::ST_IDLE: begin
        if (take) begin
          s_nxt.idx = rd_idx;
          s_nxt.ptag = req_tag;
          s_nxt.pline = cpu_pa[l1ctl_pkg::LINE_LSB +: l1ctl_pkg::LINE_ADDR_W];
          s_nxt.word = req_word;
          s_nxt.we = cpu_we;
          s_nxt.wdata = cpu_wdata;
          if (cpu_cop) begin
            // maintenance: set or clear lock of the hit entry, taken only while idle
            if (hit) begin
              s_nxt.lck[rd_idx][hit_way] = cpu_lock;
            end
            s_nxt.rsp = 1'b1;
          end else if (hit) begin
            s_nxt.rsp = 1'b1;
            s_nxt.rdata = line_q[hit_way][req_word];
            s_nxt.lru[rd_idx] = touch(s_r.lru[rd_idx], hit_way);
            if (cpu_we) begin
              // store hit writes through a locked line and leaves the lock alone
              data_we = 1'b1;
              wr_addr = {rd_idx, hit_way};
              data_wline = line_q[hit_way];
              data_wline[req_word] = cpu_wdata;
              s_nxt.drt[rd_idx][hit_way] = 1'b1;
            end
          end else begin
            s_nxt.busy = 1'b1;
            s_nxt.mreq = 1'b1;
            s_nxt.answered = 1'b0;
            s_nxt.fbufv = '0;
            s_nxt.way = vic_way;
            s_nxt.nofill = !vic_found;
            if (!vic_found) begin
              // whole set locked: single uncached word access, no allocation
              s_nxt.st = l1ctl_pkg::ST_FILL;
              s_nxt.cnt = req_word;
              s_nxt.mwe = cpu_we;
              s_nxt.maddr = {cpu_pa[31:l1ctl_pkg::WSEL_LSB], 2'b00};
              s_nxt.mwdata = cpu_wdata;
            end else if (IS_DATA && s_r.vld[rd_idx][vic_way] && s_r.drt[rd_idx][vic_way]) begin
              s_nxt.st = l1ctl_pkg::ST_WB;
              s_nxt.cnt = l1ctl_pkg::FIRST_WORD;
              s_nxt.mwe = 1'b1;
              s_nxt.maddr = {tag_q[vic_way], cpu_pa[l1ctl_pkg::LINE_LSB +: l1ctl_pkg::DC_IDX_W],
                             l1ctl_pkg::FIRST_WORD, 2'b00};
              s_nxt.mwdata = line_q[vic_way][l1ctl_pkg::FIRST_WORD];
            end else begin
              s_nxt.st = l1ctl_pkg::ST_FILL;
              s_nxt.cnt = l1ctl_pkg::FIRST_WORD;
              s_nxt.mwe = 1'b0;
              s_nxt.maddr = {cpu_pa[31:l1ctl_pkg::LINE_LSB], l1ctl_pkg::FIRST_WORD, 2'b00};
            end
          end
        end
      end
      l1ctl_pkg::ST_WB: begin
        if (mem_ack) begin
          s_nxt.cnt = 2'(s_r.cnt + 2'h1);
          if (s_r.cnt == l1ctl_pkg::LAST_WORD) begin
            s_nxt.st = l1ctl_pkg::ST_FILL;
            s_nxt.mwe = 1'b0;
            s_nxt.maddr = {s_r.pline, l1ctl_pkg::FIRST_WORD, 2'b00};
          end else begin
            s_nxt.maddr = {tag_q[s_r.way], s_r.pline[l1ctl_pkg::DC_IDX_W-1:0],
                           2'(s_r.cnt + 2'h1), 2'b00};
            s_nxt.mwdata = line_q[s_r.way][2'(s_r.cnt + 2'h1)];
          end
        end
      end
      l1ctl_pkg::ST_FILL: begin
        if (mem_ack) begin
          s_nxt.fbuf[s_r.cnt] = mem_rdata;
          s_nxt.fbufv[s_r.cnt] = 1'b1;
          if (s_r.nofill) begin
            s_nxt.rsp = 1'b1;
            s_nxt.rdata = mem_rdata;
            s_nxt.mreq = 1'b0;
            s_nxt.mwe = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.st = l1ctl_pkg::ST_IDLE;
          end else begin
            // critical word goes straight from the external data to the core
            if (s_r.cnt == s_r.word && !s_r.we && !s_r.answered) begin
              s_nxt.rsp = 1'b1;
              s_nxt.rdata = mem_rdata;
              s_nxt.answered = 1'b1;
            end
            if (s_r.cnt == l1ctl_pkg::LAST_WORD) begin
              s_nxt.mreq = 1'b0;
              s_nxt.st = l1ctl_pkg::ST_INST;
            end else begin
              s_nxt.cnt = 2'(s_r.cnt + 2'h1);
              s_nxt.maddr = {s_r.pline, 2'(s_r.cnt + 2'h1), 2'b00};
            end
          end
        end
        // later fetches to words of the same line that are already in the buffer are bypassed out of it
        if (!IS_DATA && s_r.answered && take && !cpu_cop &&
            cpu_pa[l1ctl_pkg::LINE_LSB +: l1ctl_pkg::LINE_ADDR_W] == s_r.pline &&
            s_r.fbufv[req_word]) begin
          s_nxt.rsp = 1'b1;
          s_nxt.rdata = s_r.fbuf[req_word];
        end
      end
      l1ctl_pkg::ST_INST: begin
        tag_we = 1'b1;
        data_we = 1'b1;
        if (s_r.we) begin
          data_wline[s_r.word] = s_r.wdata;
        end
        s_nxt.vld[s_r.idx][s_r.way] = 1'b1;
        s_nxt.lck[s_r.idx][s_r.way] = 1'b0;
        s_nxt.drt[s_r.idx][s_r.way] = IS_DATA && s_r.we;
        s_nxt.lru[s_r.idx] = touch(s_r.lru[s_r.idx], s_r.way);
        if (!s_r.answered) begin
          s_nxt.rsp = 1'b1;
          s_nxt.rdata = s_r.fbuf[s_r.word];
        end
        s_nxt.busy = 1'b0;
        s_nxt.st = l1ctl_pkg::ST_IDLE;
      end
      default: begin
        s_nxt.st = l1ctl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // storage arrays carry no reset; valid bits guard them
  always_ff @(posedge sys_clk) begin
    if (tag_we) begin
      tag_mem[wr_addr] <= s_r.ptag;
    end
    if (data_we) begin
      data_mem[wr_addr] <= data_wline;
    end
  end

  assign cpu_rsp = s_r.rsp;
  assign cpu_rdata = s_r.rdata;
  assign cpu_busy = s_r.busy;
  assign mem_req = s_r.mreq;
  assign mem_we = s_r.mwe;
  assign mem_addr = s_r.maddr;
  assign mem_wdata = s_r.mwdata;
endmodule : l1ctl_cache

module l1ctl_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ic_req,
  input wire logic ic_cop,
  input wire logic ic_lock,
  input wire logic [31:0] ic_va,
  input wire logic [31:0] ic_pa,
  output logic ic_rsp,
  output logic [31:0] ic_rdata,
  output logic ic_busy,
  output logic im_req,
  output logic [31:0] im_addr,
  input wire logic im_ack,
  input wire logic [31:0] im_rdata,
  input wire logic dc_req,
  input wire logic dc_we,
  input wire logic dc_cop,
  input wire logic dc_lock,
  input wire logic [31:0] dc_va,
  input wire logic [31:0] dc_pa,
  input wire logic [31:0] dc_wdata,
  output logic dc_rsp,
  output logic [31:0] dc_rdata,
  output logic dc_busy,
  output logic dm_req,
  output logic dm_we,
  output logic [31:0] dm_addr,
  output logic [31:0] dm_wdata,
  input wire logic dm_ack,
  input wire logic [31:0] dm_rdata
);
  l1ctl_cache #(.IS_DATA(1'b0)) u_icache (
    .sys_clk(sys_clk), .reset(reset),
    .cpu_req(ic_req), .cpu_we(1'b0), .cpu_cop(ic_cop), .cpu_lock(ic_lock),
    .cpu_va(ic_va), .cpu_pa(ic_pa), .cpu_wdata(32'h0000_0000),
    .cpu_rsp(ic_rsp), .cpu_rdata(ic_rdata), .cpu_busy(ic_busy),
    .mem_req(im_req), .mem_we(), .mem_addr(im_addr), .mem_wdata(),
    .mem_ack(im_ack), .mem_rdata(im_rdata)
  );

  l1ctl_cache #(.IS_DATA(1'b1)) u_dcache (
    .sys_clk(sys_clk), .reset(reset),
    .cpu_req(dc_req), .cpu_we(dc_we), .cpu_cop(dc_cop), .cpu_lock(dc_lock),
    .cpu_va(dc_va), .cpu_pa(dc_pa), .cpu_wdata(dc_wdata),
    .cpu_rsp(dc_rsp), .cpu_rdata(dc_rdata), .cpu_busy(dc_busy),
    .mem_req(dm_req), .mem_we(dm_we), .mem_addr(dm_addr), .mem_wdata(dm_wdata),
    .mem_ack(dm_ack), .mem_rdata(dm_rdata)
  );
endmodule : l1ctl_top

`default_nettype wire

// >>> l1ctl_top_sva.sv
// port assertions for the cache control top
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module l1ctl_top_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ic_req,
  input wire logic ic_rsp,
  input wire logic ic_busy,
  input wire logic im_req,
  input wire logic im_ack,
  input wire logic [31:0] im_addr,
  input wire logic dc_req,
  input wire logic dc_rsp,
  input wire logic dc_busy,
  input wire logic dm_req,
  input wire logic dm_ack,
  input wire logic dm_we,
  input wire logic [31:0] dm_addr,
  input wire logic [31:0] dm_wdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_rst_quiet: assert property (disable iff (1'b0) reset |=> !ic_rsp && !ic_busy && !im_req
    && !dc_rsp && !dc_busy && !dm_req) else $error("outputs not cleared by reset");
  a_ic_rsp_pulse: assert property (ic_rsp |=> !ic_rsp) else $error("ic answer too long");
  a_dc_rsp_pulse: assert property (dc_rsp |=> !dc_rsp) else $error("dc answer too long");
  a_im_req_hold: assert property (im_req && !im_ack |=> im_req && $stable(im_addr))
    else $error("im request dropped early");
  a_dm_req_hold: assert property (dm_req && !dm_ack |=> dm_req
    && $stable({dm_we, dm_addr, dm_wdata})) else $error("dm request dropped early");
  a_im_next_word: assert property (im_req && im_ack && im_addr[3:2] != 2'h3
    |=> im_req && im_addr == $past(im_addr) + 32'h4) else $error("fill word order");
  a_dm_next_word: assert property (dm_req && dm_ack && dm_addr[3:2] != 2'h3
    |=> dm_req && dm_addr == $past(dm_addr) + 32'h4) else $error("dm word order");
  a_ic_answer: assert property (ic_req && !ic_busy && !ic_rsp |-> ##[1:40] ic_rsp)
    else $error("ic answer missing");
  a_dc_answer: assert property (dc_req && !dc_busy && !dc_rsp |-> ##[1:40] dc_rsp)
    else $error("dc answer missing");
  a_im_in_miss: assert property (im_req |-> ic_busy) else $error("im traffic while idle");
  c_bypass: cover property (ic_busy && ic_rsp);
  c_wback: cover property (dm_req && dm_we && dm_ack);
  c_ic_hit: cover property (ic_rsp && !ic_busy);
endmodule : l1ctl_top_sva
bind l1ctl_top l1ctl_top_sva u_sva (.sys_clk(sys_clk), .reset(reset), .ic_req(ic_req),
  .ic_rsp(ic_rsp), .ic_busy(ic_busy), .im_req(im_req), .im_ack(im_ack), .im_addr(im_addr),
  .dc_req(dc_req), .dc_rsp(dc_rsp), .dc_busy(dc_busy), .dm_req(dm_req), .dm_ack(dm_ack),
  .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata));
`default_nettype wire

// >>> tb_l1_cache_tag_lock_replace.sv
// self-checking bench for the cache control top
// assumes memory models on both sides; inputs move at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_l1_cache_tag_lock_replace;
  localparam logic [31:0] K = 32'hc3c3_c3c3;
  localparam logic [31:0] V = 32'h1234_5678;
  typedef struct {bit d; bit we; logic [31:0] va; logic [31:0] pa; logic [31:0] v; bit hit;}
    l1ctl_row_type;
  l1ctl_row_type rows [7] = '{
    '{0, 0, 32'h1004, 32'h1004, 32'h1004 ^ K, 0},
    '{0, 0, 32'h1004, 32'h1004, 32'h1004 ^ K, 1},
    '{0, 0, 32'h100c, 32'h100c, 32'h100c ^ K, 1},
    '{0, 0, 32'h1004, 32'h5004, 32'h5004 ^ K, 0},
    '{1, 0, 32'h2008, 32'h2008, 32'h2008 ^ K, 0},
    '{1, 1, 32'h2008, 32'h2008, V, 1},
    '{1, 0, 32'h2008, 32'h2008, V, 1}};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic ic_req = 0, ic_cop = 0, ic_lock = 0, dc_req = 0, dc_we = 0, dc_cop = 0, dc_lock = 0;
  logic [31:0] ic_va = 0, ic_pa = 0, dc_va = 0, dc_pa = 0, dc_wdata = 0;
  logic ic_rsp, ic_busy, im_req, im_ack, dc_rsp, dc_busy, dm_req, dm_we, dm_ack;
  logic [31:0] ic_rdata, im_addr, im_rdata, dc_rdata, dm_addr, dm_wdata, dm_rdata;
  logic [31:0] rd;
  int lat;
  int n_errors = 0;
  int comparisons = 0;
  always #12.5 sys_clk = ~sys_clk;
  l1ctl_top dut (.sys_clk(sys_clk), .reset(reset), .ic_req(ic_req), .ic_cop(ic_cop),
    .ic_lock(ic_lock), .ic_va(ic_va), .ic_pa(ic_pa), .ic_rsp(ic_rsp), .ic_rdata(ic_rdata),
    .ic_busy(ic_busy), .im_req(im_req), .im_addr(im_addr), .im_ack(im_ack),
    .im_rdata(im_rdata), .dc_req(dc_req), .dc_we(dc_we), .dc_cop(dc_cop), .dc_lock(dc_lock),
    .dc_va(dc_va), .dc_pa(dc_pa), .dc_wdata(dc_wdata), .dc_rsp(dc_rsp), .dc_rdata(dc_rdata),
    .dc_busy(dc_busy), .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_ack(dm_ack), .dm_rdata(dm_rdata));
  // slow instruction memory keeps the fill going while the bypass is tried
  l1ctl_mem_model #(.DLY(3)) imem (.sys_clk(sys_clk), .reset(reset), .req(im_req),
    .we(1'b0), .addr(im_addr), .wdata(32'h0), .ack(im_ack), .rdata(im_rdata));
  l1ctl_mem_model #(.DLY(0)) dmem (.sys_clk(sys_clk), .reset(reset), .req(dm_req),
    .we(dm_we), .addr(dm_addr), .wdata(dm_wdata), .ack(dm_ack), .rdata(dm_rdata));
  function automatic logic [31:0] la(input int n);
    return 32'h10 + n * 32'h1000;
  endfunction : la
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t data got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_hit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_hit
  task automatic acc(input bit d, input bit we, input bit cop, input bit lk,
                     input logic [31:0] va, input logic [31:0] pa, input logic [31:0] wd,
                     input bit nb);
    repeat (300) if (!nb && (d ? dc_busy : ic_busy) === 1'b1) @(negedge sys_clk);
    if (!nb && (d ? dc_busy : ic_busy) === 1'b1) n_errors++;
    if (d) begin
      {dc_req, dc_we, dc_cop, dc_lock, dc_va, dc_pa, dc_wdata} = {1'b1, we, cop, lk, va, pa, wd};
    end else begin
      {ic_req, ic_cop, ic_lock, ic_va, ic_pa} = {1'b1, cop, lk, va, pa};
    end
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while ((d ? dc_rsp : ic_rsp) !== 1'b1 && lat < 300);
    if (lat >= 300) n_errors++;
    rd = d ? dc_rdata : ic_rdata;
    dc_req = 1'b0;
    ic_req = 1'b0;
    @(negedge sys_clk);
  endtask : acc
  task automatic ld(input bit d, input logic [31:0] a);
    acc(d, 1'b0, 1'b0, 1'b0, a, a, 32'h0, 1'b0);
  endtask : ld
  task automatic results();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    results();
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    foreach (rows[i]) begin
      acc(rows[i].d, rows[i].we, 1'b0, 1'b0, rows[i].va, rows[i].pa, rows[i].v, 1'b0);
      chk_hit(lat == 1, rows[i].hit);
      if (!rows[i].we) chk_data(rd, rows[i].v);
      $display("row %0d done", i);
    end
    for (int d = 0; d < 2; d++) begin
      for (int n = 0; n < 4; n++) ld(d[0], la(n));
      acc(d[0], 1'b0, 1'b1, 1'b1, la(0), la(0), 32'h0, 1'b0);
      if (d == 1) acc(1'b1, 1'b1, 1'b0, 1'b0, la(0), la(0), V, 1'b0);
      // reverse order leaves the highest unlocked way oldest, so a first-free pick shows up
      for (int n = 3; n > 0; n--) ld(d[0], la(n));
      ld(d[0], la(4));
      ld(d[0], la(0));
      chk_hit(lat == 1, 1'b1);
      chk_data(rd, d == 1 ? V : la(0) ^ K);
      ld(d[0], la(1));
      chk_hit(lat == 1, 1'b1);
      ld(d[0], la(3));
      chk_hit(lat == 1, 1'b0);
      $display("lock test side %0d done", d);
    end
    acc(1'b1, 1'b0, 1'b1, 1'b0, la(0), la(0), 32'h0, 1'b0);
    for (int n = 3; n < 6; n++) ld(1'b1, la(n == 5 ? 1 : n));
    ld(1'b1, la(5));
    chk_data(dmem.n_wr, 32'h4);
    chk_data(dmem.mem[la(0)], V);
    ld(1'b1, la(0));
    chk_data(rd, V);
    acc(1'b1, 1'b1, 1'b0, 1'b0, 32'h2108, 32'h2108, V, 1'b0);
    chk_hit(lat == 1, 1'b0);
    ld(1'b1, 32'h2108);
    chk_data(rd, V);
    $display("write-back test done");
    ld(1'b0, 32'h0002_0020);
    acc(1'b0, 1'b0, 1'b0, 1'b0, 32'h0002_0020, 32'h0002_0020, 32'h0, 1'b1);
    chk_hit(lat == 1, 1'b1);
    chk_data(rd, 32'h0002_0020 ^ K);
    $display("bypass test done");
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_hit(ic_rsp | ic_busy | im_req | dc_rsp | dc_busy | dm_req, 1'b0);
    reset = 1'b0;
    ld(1'b0, 32'h1004);
    chk_hit(lat == 1, 1'b0);
    $display("reset test done");
    results();
  end
endmodule : tb_l1_cache_tag_lock_replace
`default_nettype wire
